// *** rtl/spss_pkg.sv ***
// Constants and types for the startup and power state sequencer
// Functional notes
// - Start on power-on reset or reset pin
// - Synchronize reset, load config, apply I/O
// - Both pins low after load: programming
// - Reset only: minimum energy until release
// - Reset release: boot, then active
// - Programming mode suspends normal operation
// - Pick lowest-power operational state
// - Active: oscillator on, CPU run/sleep
// - Peripherals and DMA move active/doze
// - Doze only when CPU and peripherals idle
// - Doze retains state and timekeeping
// - Doze wakes on pin activity
// - Doze keeps slow oscillator and timers
// - Config page: hardware and software parts; loader reads only from SPSS_HW_CFG_BASE, software word is word 1
package spss_pkg;

	// ----------------------------------------
	// Counts and reset values
	// ----------------------------------------
	localparam int SPSS_CFG_WORDS = 16;
	localparam int SPSS_IO_WIDTH = 16;
	localparam int SPSS_ADDR_W = 9;
	localparam int SPSS_BOOT_CYCLES = 64;
	localparam logic [SPSS_IO_WIDTH-1:0] SPSS_IO_DIR_RST = 16'h0000;
	localparam logic [SPSS_ADDR_W-1:0] SPSS_HW_CFG_BASE = 9'h000;
	localparam logic [SPSS_ADDR_W-1:0] SPSS_SW_CFG_BASE = 9'h100;

	// ----------------------------------------
	// States
	// ----------------------------------------
	typedef enum logic [8:0] {
		SPSS_POR = 9'h001,
		SPSS_LOAD = 9'h002,
		SPSS_SAMPLE = 9'h004,
		SPSS_PROG = 9'h008,
		SPSS_MIN_ENERGY = 9'h010,
		SPSS_BOOT = 9'h020,
		SPSS_CPU_ACTIVE = 9'h040,
		SPSS_CPU_IDLE = 9'h080,
		SPSS_DOZE = 9'h100
	} spss_state_t;

	// Wake sources watched while dozing
	typedef struct packed {
		logic uart_rx_a;
		logic uart_rx_b;
		logic time_capture;
	} spss_wake_t;

	// Power controls driven out
	typedef struct packed {
		logic relax_osc_en;
		logic lf_osc_en;
		logic lf_timer_en;
		logic periph_clk_en;
		logic cpu_clk_en;
		logic retain;
	} spss_pwr_t;

endpackage

// *** rtl/spss_sequencer.sv ***
// Startup and power state sequencer top module
`timescale 1ns/10ps
`default_nettype none
module spss_sequencer import spss_pkg::*; #(
	parameter int CFG_WORDS = SPSS_CFG_WORDS,
	parameter int BOOT_CYCLES = SPSS_BOOT_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic por_done,
	input wire logic ext_reset_in_n,
	input wire logic program_mode_select_n,
	input wire logic time_capture_request_n,
	input wire logic uart_rx_a,
	input wire logic uart_rx_b,
	input wire logic cpu_sleep_req,
	input wire logic cpu_wake_req,
	input wire logic periph_busy,
	input wire logic dma_busy,
	input wire logic [15:0] cfg_rdata,
	output logic [SPSS_ADDR_W-1:0] cfg_addr,
	output logic cfg_rd,
	output logic [SPSS_IO_WIDTH-1:0] io_dir,
	output logic [15:0] sw_cfg_word,
	output logic prog_mode,
	output logic normal_run,
	output spss_pwr_t pwr,
	output spss_state_t state
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Pins are asynchronous; two stages before any use.
	// Reset shows the pins idle but por_done low, so start-up never runs
	// ahead of the supply flag; receive and capture lines idle inactive.
	logic [5:0] sync1;
	logic [5:0] sync2;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync1 <= 6'h1f;
			sync2 <= 6'h1f;
		end else begin
			sync1 <= {por_done, ext_reset_in_n, program_mode_select_n,
				time_capture_request_n, uart_rx_a, uart_rx_b};
			sync2 <= sync1;
		end
	end

	wire por_s = sync2[5];
	wire rst_low = !sync2[4];
	wire prog_low = !sync2[3];
	spss_wake_t wake_lvl;
	assign wake_lvl = '{uart_rx_a: sync2[1], uart_rx_b: sync2[0],
		time_capture: !sync2[2]};

	// Edge memory for reset fall and wake pin activity
	logic rst_low_d;
	spss_wake_t wake_d;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rst_low_d <= 1'b0;
			wake_d <= '1;
		end else begin
			rst_low_d <= rst_low;
			wake_d <= wake_lvl;
		end
	end
	wire rst_fall = rst_low && !rst_low_d;
	// Receive start bits fall, capture request asserts high after inversion.
	wire pin_wake = (wake_d.uart_rx_a && !wake_lvl.uart_rx_a)
		|| (wake_d.uart_rx_b && !wake_lvl.uart_rx_b)
		|| (!wake_d.time_capture && wake_lvl.time_capture);

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	wire sys_busy = periph_busy || dma_busy;
	wire all_idle = !sys_busy && cpu_sleep_req && !cpu_wake_req;
	localparam int CW = $clog2(CFG_WORDS + 1);
	localparam int BW = $clog2(BOOT_CYCLES + 1);
	logic [CW-1:0] load_cnt;
	logic [BW-1:0] boot_cnt;
	wire load_last = load_cnt == CW'(CFG_WORDS - 1);
	wire boot_last = boot_cnt == BW'(BOOT_CYCLES - 1);

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	spss_state_t next_state;
	always_comb begin
		next_state = state;
		case (state)
			SPSS_POR: if (por_s) next_state = SPSS_LOAD;
			SPSS_LOAD: if (load_last) next_state = SPSS_SAMPLE;
			SPSS_SAMPLE: begin
				// Both low requests programming; reset alone parks.
				if (rst_low && prog_low) next_state = SPSS_PROG;
				else if (rst_low) next_state = SPSS_MIN_ENERGY;
				else next_state = SPSS_BOOT;
			end
			SPSS_PROG: if (!rst_low) next_state = SPSS_BOOT;
			SPSS_MIN_ENERGY: if (!rst_low) next_state = SPSS_BOOT;
			SPSS_BOOT: if (boot_last) next_state = SPSS_CPU_ACTIVE;
			SPSS_CPU_ACTIVE: begin
				if (all_idle) next_state = SPSS_DOZE;
				else if (cpu_sleep_req && !cpu_wake_req) next_state = SPSS_CPU_IDLE;
			end
			SPSS_CPU_IDLE: begin
				if (cpu_wake_req) next_state = SPSS_CPU_ACTIVE;
				else if (!sys_busy) next_state = SPSS_DOZE;
			end
			SPSS_DOZE: begin
				// Peripherals or DMA wake without the CPU.
				if (cpu_wake_req) next_state = SPSS_CPU_ACTIVE;
				else if (sys_busy || pin_wake) next_state = SPSS_CPU_IDLE;
			end
			default: next_state = SPSS_POR;
		endcase
		// Reset pin fall restarts from config load in any later state.
		if (state != SPSS_POR && state != SPSS_LOAD && rst_fall)
			next_state = SPSS_LOAD;
	end

	always_ff @(posedge clk) begin
		if (!rstn) state <= SPSS_POR;
		else state <= next_state;
	end

	// ----------------------------------------
	// Config page loader
	// ----------------------------------------
	// Words are read from the hardware base; word 0 sets I/O direction, word 1 is kept as the software word.
	wire in_load = state == SPSS_LOAD;
	assign cfg_rd = in_load;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			load_cnt <= '0;
			cfg_addr <= SPSS_HW_CFG_BASE;
		end else if (in_load && !load_last) begin
			load_cnt <= load_cnt + CW'(1);
			cfg_addr <= cfg_addr + SPSS_ADDR_W'(1);
		end else if (!in_load) begin
			load_cnt <= '0;
			cfg_addr <= SPSS_HW_CFG_BASE;
		end
	end

	// Read data follows address by one cycle; word 0 is I/O direction.
	logic in_load_d;
	logic [CW-1:0] load_cnt_d;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			in_load_d <= 1'b0;
			load_cnt_d <= '0;
			io_dir <= SPSS_IO_DIR_RST;
			sw_cfg_word <= 16'h0000;
		end else begin
			in_load_d <= in_load;
			load_cnt_d <= load_cnt;
			if (in_load_d && load_cnt_d == '0) io_dir <= cfg_rdata;
			if (in_load_d && load_cnt_d == CW'(1)) sw_cfg_word <= cfg_rdata;
		end
	end

	// Boot timer
	always_ff @(posedge clk) begin
		if (!rstn) boot_cnt <= '0;
		else if (state == SPSS_BOOT && !boot_last) boot_cnt <= boot_cnt + BW'(1);
		else if (state != SPSS_BOOT) boot_cnt <= '0;
	end

	// ----------------------------------------
	// Power outputs
	// ----------------------------------------
	// Registered so clock gates never glitch on decode hazards.
	wire nx_op = next_state inside {SPSS_CPU_ACTIVE, SPSS_CPU_IDLE, SPSS_DOZE};
	wire nx_doze = next_state == SPSS_DOZE;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pwr <= '0;
			prog_mode <= 1'b0;
			normal_run <= 1'b0;
		end else begin
			pwr.relax_osc_en <= !nx_doze && next_state != SPSS_MIN_ENERGY;
			pwr.lf_osc_en <= nx_op;
			pwr.lf_timer_en <= nx_op;
			pwr.periph_clk_en <= nx_op && !nx_doze;
			pwr.cpu_clk_en <= next_state == SPSS_CPU_ACTIVE
				|| next_state == SPSS_BOOT;
			pwr.retain <= nx_doze;
			prog_mode <= next_state == SPSS_PROG;
			normal_run <= nx_op;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	doze_needs_idle_a: assert property (@(posedge clk) disable iff (!rstn)
		(state != SPSS_DOZE && next_state == SPSS_DOZE) |-> !sys_busy && !cpu_wake_req)
		else $error("doze entered while busy");
	prog_entry_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_SAMPLE && rst_low && prog_low) |=> state == SPSS_PROG)
		else $error("programming mode not entered");
	min_energy_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_SAMPLE && rst_low && !prog_low) |=> state == SPSS_MIN_ENERGY)
		else $error("minimum energy not entered");
	min_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_MIN_ENERGY && rst_low) |=> state == SPSS_MIN_ENERGY)
		else $error("left minimum energy under reset");
	boot_to_active_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(state == SPSS_BOOT) |-> ##[1:300] state == SPSS_CPU_ACTIVE)
		else $error("boot did not reach active");
	prog_suspends_a: assert property (@(posedge clk) disable iff (!rstn)
		state == SPSS_PROG |=> !normal_run)
		else $error("normal run during programming");
	doze_clocks_a: assert property (@(posedge clk) disable iff (!rstn)
		state == SPSS_DOZE && $past(state) == SPSS_DOZE |->
		pwr.lf_osc_en && pwr.lf_timer_en && !pwr.relax_osc_en && pwr.retain)
		else $error("doze clock settings wrong");
	doze_wake_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_DOZE && pin_wake && !rst_fall) |=> state != SPSS_DOZE)
		else $error("no wake on pin activity");
	config_load_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(state == SPSS_LOAD) |-> cfg_rd [*2])
		else $error("config load not reading");

	// Start-up steps; pin decisions use only synchronised pins, config load steps follow the load counter
	por_wait_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_POR && !por_s)
		|=> state == SPSS_POR)
		else $error("left power-on wait early");
	pin_restart_a: assert property (@(posedge clk) disable iff (!rstn)
		(state != SPSS_POR && state != SPSS_LOAD && rst_fall)
		|=> state == SPSS_LOAD)
		else $error("reset pin fall did not restart");
	load_end_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_LOAD && load_last)
		|=> state == SPSS_SAMPLE)
		else $error("config load did not end");
	load_step_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_LOAD && !load_last)
		|=> cfg_addr == $past(cfg_addr) + SPSS_ADDR_W'(1))
		else $error("config address did not step");
	// Data lags the address by one cycle, so the past sample is the word read
	io_dir_load_a: assert property (@(posedge clk) disable iff (!rstn)
		(in_load_d && load_cnt_d == '0)
		|=> io_dir == $past(cfg_rdata))
		else $error("I/O direction not taken from word 0");
	sw_word_load_a: assert property (@(posedge clk) disable iff (!rstn)
		(in_load_d && load_cnt_d == CW'(1))
		|=> sw_cfg_word == $past(cfg_rdata))
		else $error("software word not taken from word 1");
	sample_boot_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_SAMPLE && !rst_low)
		|=> state == SPSS_BOOT)
		else $error("released reset did not boot");
	min_energy_off_a: assert property (@(posedge clk) disable iff (!rstn)
		state == SPSS_MIN_ENERGY
		|-> !pwr.relax_osc_en && !pwr.cpu_clk_en && !normal_run)
		else $error("minimum energy left clocks running");
	prog_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_PROG && rst_low && !rst_fall)
		|=> state == SPSS_PROG)
		else $error("left programming mode under reset");
	prog_clocks_a: assert property (@(posedge clk) disable iff (!rstn)
		state == SPSS_PROG
		|-> prog_mode && !pwr.cpu_clk_en && !pwr.periph_clk_en)
		else $error("normal clocks on in programming mode");

	// Operational group moves
	active_clocks_a: assert property (@(posedge clk) disable iff (!rstn)
		state == SPSS_CPU_ACTIVE
		|-> pwr.relax_osc_en && pwr.cpu_clk_en && pwr.periph_clk_en)
		else $error("active state clocks wrong");
	idle_clocks_a: assert property (@(posedge clk) disable iff (!rstn)
		state == SPSS_CPU_IDLE
		|-> pwr.relax_osc_en && !pwr.cpu_clk_en && pwr.periph_clk_en)
		else $error("inactive state clocks wrong");
	doze_cpu_wake_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_DOZE && cpu_wake_req && !rst_fall)
		|=> state == SPSS_CPU_ACTIVE)
		else $error("cpu wake did not leave doze");
	lowest_power_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_CPU_IDLE && !sys_busy && !cpu_wake_req && !rst_fall)
		|=> state == SPSS_DOZE)
		else $error("idle system did not doze");
	busy_wake_a: assert property (@(posedge clk) disable iff (!rstn)
		(state == SPSS_DOZE && sys_busy && !cpu_wake_req && !rst_fall)
		|=> state == SPSS_CPU_IDLE)
		else $error("peripheral activity did not wake");

	// Doze keeps its context and gates the fast clocks
	doze_retains_a: assert property (@(posedge clk) disable iff (!rstn)
		state == SPSS_DOZE
		|-> $stable(io_dir) && $stable(sw_cfg_word))
		else $error("context changed in doze");
	doze_gated_a: assert property (@(posedge clk) disable iff (!rstn)
		state == SPSS_DOZE
		|-> !pwr.cpu_clk_en && !pwr.periph_clk_en)
		else $error("fast clocks running in doze");

endmodule // spss_sequencer
`default_nettype wire

// *** bench/spss_host_model.sv ***
// Host pin driver and config page model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module spss_host_model import spss_pkg::*; #(
	parameter logic [15:0] IO_WORD = 16'ha5c3,
	parameter logic [15:0] SW_WORD = 16'h3c5a
) (
	input wire logic clk,
	input wire logic hold_reset,
	input wire logic hold_prog,
	input wire logic [SPSS_ADDR_W-1:0] cfg_addr,
	input wire logic cfg_rd,
	output logic ext_reset_in_n,
	output logic program_mode_select_n,
	output logic [15:0] cfg_rdata
);
	logic [SPSS_ADDR_W-1:0] addr_q = '0;
	logic rd_q = 1'b0;
	initial begin
		ext_reset_in_n = 1'b1;
		program_mode_select_n = 1'b1;
		cfg_rdata = 16'h0f0f;
	end
	// Both pins move on one edge so they are sampled together
	always @(negedge clk) begin
		ext_reset_in_n <= ~hold_reset;
		program_mode_select_n <= ~hold_prog;
		// Page answers one cycle after the address, as the loader expects
		addr_q <= cfg_addr;
		rd_q <= cfg_rd;
		// Data is only valid for a read; otherwise it toggles every cycle
		if (rd_q)
			cfg_rdata <= (addr_q == SPSS_HW_CFG_BASE) ? IO_WORD : SW_WORD;
		else
			cfg_rdata <= ~cfg_rdata;
	end
endmodule // spss_host_model
`default_nettype wire

// *** bench/tb.sv ***
// Self-checking testbench for the startup and power state sequencer
`timescale 1ns/10ps
`default_nettype none
module tb import spss_pkg::*;;
	logic clk, rstn, por_done, hold_reset, hold_prog, sleep, wake, pbusy, dbusy;
	logic ext_n, prog_n, cfg_rd, prog_mode, normal_run;
	logic [15:0] rdata, io_dir, sw_word;
	logic [SPSS_ADDR_W-1:0] addr;
	spss_wake_t wk;
	spss_pwr_t pwr;
	spss_state_t state;
	int mismatches = 0;
	int cmp_count = 0;
	spss_host_model host (.clk(clk), .hold_reset(hold_reset), .hold_prog(hold_prog),
		.cfg_addr(addr), .cfg_rd(cfg_rd), .ext_reset_in_n(ext_n),
		.program_mode_select_n(prog_n), .cfg_rdata(rdata));
	spss_sequencer #(.CFG_WORDS(2), .BOOT_CYCLES(4)) dut (.clk(clk), .rstn(rstn),
		.por_done(por_done), .ext_reset_in_n(ext_n), .program_mode_select_n(prog_n),
		.time_capture_request_n(wk.time_capture), .uart_rx_a(wk.uart_rx_a),
		.uart_rx_b(wk.uart_rx_b), .cpu_sleep_req(sleep), .cpu_wake_req(wake),
		.periph_busy(pbusy), .dma_busy(dbusy), .cfg_rdata(rdata), .cfg_addr(addr),
		.cfg_rd(cfg_rd), .io_dir(io_dir), .sw_cfg_word(sw_word), .prog_mode(prog_mode),
		.normal_run(normal_run), .pwr(pwr), .state(state));
	// ----------------------------------------
	// Clock, checks and waits
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Bounded wait; the caller judges the state reached
	task automatic wait_st(input spss_state_t s, input int lim);
		for (int n = 0; n < lim && state !== s; n++) @(negedge clk);
	endtask
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_boot();
		repeat (8) @(negedge clk);
		check("por_hold", state, SPSS_POR);
		por_done = 1'b1;
		wait_st(SPSS_LOAD, 6);
		check("load_rd", cfg_rd, 1'b1);
		wait_st(SPSS_BOOT, 10);
		check("io_dir", io_dir, 16'ha5c3);
		check("sw_word", sw_word, 16'h3c5a);
		wait_st(SPSS_CPU_ACTIVE, 10);
		check("active", state, SPSS_CPU_ACTIVE);
		check("relax_osc", pwr.relax_osc_en, 1'b1);
		check("run", normal_run, 1'b1);
	endtask
	task automatic t_power();
		sleep = 1'b1;
		pbusy = 1'b1;
		repeat (4) @(negedge clk);
		check("busy_idle", state, SPSS_CPU_IDLE);
		pbusy = 1'b0;
		wait_st(SPSS_DOZE, 4);
		check("doze", state, SPSS_DOZE);
		check("slow_clk", {pwr.lf_osc_en, pwr.lf_timer_en, pwr.cpu_clk_en, pwr.periph_clk_en},
			4'b1100);
		check("retain", {pwr.retain, io_dir}, {1'b1, 16'ha5c3});
		dbusy = 1'b1;
		wait_st(SPSS_CPU_IDLE, 4);
		check("dma_wake", state, SPSS_CPU_IDLE);
		dbusy = 1'b0;
		wait_st(SPSS_DOZE, 4);
		check("dma_doze", state, SPSS_DOZE);
		// Each wake line in turn, returning to doze after each
		for (int i = 0; i < 3; i++) begin
			wk[i] = 1'b0;
			wait_st(SPSS_CPU_IDLE, 6);
			check("pin_wake", state, SPSS_CPU_IDLE);
			wk[i] = 1'b1;
			wait_st(SPSS_DOZE, 4);
		end
		sleep = 1'b0;
		wake = 1'b1;
		wait_st(SPSS_CPU_ACTIVE, 4);
		check("cpu_wake", state, SPSS_CPU_ACTIVE);
		wake = 1'b0;
	endtask
	task automatic t_min_energy();
		hold_reset = 1'b1;
		wait_st(SPSS_LOAD, 8);
		check("pin_load", state, SPSS_LOAD);
		wait_st(SPSS_MIN_ENERGY, 10);
		repeat (10) @(negedge clk);
		check("min_energy", state, SPSS_MIN_ENERGY);
		check("min_run", {normal_run, prog_mode, pwr.relax_osc_en}, 3'b000);
		hold_reset = 1'b0;
		wait_st(SPSS_BOOT, 8);
		check("rel_boot", state, SPSS_BOOT);
		wait_st(SPSS_CPU_ACTIVE, 10);
		check("rel_act", state, SPSS_CPU_ACTIVE);
	endtask
	task automatic t_prog();
		hold_reset = 1'b1;
		hold_prog = 1'b1;
		wait_st(SPSS_PROG, 20);
		repeat (10) @(negedge clk);
		check("prog", state, SPSS_PROG);
		check("prog_out", {prog_mode, normal_run}, 2'b10);
		hold_reset = 1'b0;
		hold_prog = 1'b0;
		wait_st(SPSS_CPU_ACTIVE, 20);
		check("prog_exit", state, SPSS_CPU_ACTIVE);
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		{rstn, por_done, hold_reset, hold_prog, sleep, wake, pbusy, dbusy} = '0;
		wk = '1;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		t_boot();
		t_power();
		t_min_energy();
		t_prog();
		test_done();
	end
	initial begin
		#400000;
		mismatches++;
		test_done();
	end
endmodule // tb
`default_nettype wire
